// [hdl/aet_pkg.sv]
// Package for the accidental energize trip block: register map, field
// codes, reset values, timing constants and the carrier structs.
// Assumes a 50 MHz system clock and magnitudes in hundredths of rated.
`default_nettype none
package aet_pkg;
    // Timing
    localparam int unsigned CLK_HZ      = 50_000_000;
    localparam int unsigned CYCLE_US    = 5000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1_000_000 * CYCLE_US;
    // Widths and depths
    localparam int unsigned MAG_W = 16;
    localparam int unsigned DLY_W = 19;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned TS_W  = 32;
    localparam int unsigned AW    = 8;
    localparam int unsigned DW    = 32;
    localparam int unsigned LOG_N = 12;
    // Register offsets (byte addresses)
    localparam logic [7:0] A_GEN   = 8'h00;
    localparam logic [7:0] A_MODE  = 8'h04;
    localparam logic [7:0] A_FORCE = 8'h08;
    localparam logic [7:0] A_UVLIM = 8'h0C;
    localparam logic [7:0] A_ACTD  = 8'h10;
    localparam logic [7:0] A_RELD  = 8'h14;
    localparam logic [7:0] A_ILIM  = 8'h18;
    localparam logic [7:0] A_EVSEL = 8'h1C;
    localparam logic [7:0] A_STAT  = 8'h20;
    localparam logic [7:0] A_EXPT  = 8'h24;
    localparam logic [7:0] A_REMT  = 8'h28;
    localparam logic [7:0] A_VRAT  = 8'h2C;
    localparam logic [7:0] A_IRAT  = 8'h30;
    localparam logic [7:0] A_CSTA  = 8'h34;
    localparam logic [7:0] A_CTRP  = 8'h38;
    localparam logic [7:0] A_CBLK  = 8'h3C;
    localparam logic [7:0] A_CCLR  = 8'h40;
    localparam logic [7:0] A_LSEL  = 8'h44;
    localparam logic [7:0] A_LDAT  = 8'h48;
    localparam logic [7:0] A_LCNT  = 8'h4C;
    // Reset values and limits
    localparam logic [13:0] UV_DEF    = 14'h1388;
    localparam logic [13:0] UV_MAX    = 14'h26AC;
    localparam logic [18:0] ACT_DEF   = 19'h003E8;
    localparam logic [18:0] REL_DEF   = 19'h00032;
    localparam logic [18:0] DLY_MAX   = 19'h57E40;
    localparam logic [5:0]  ILIM_DEF  = 6'h01;
    localparam logic [5:0]  ILIM_MAX  = 6'h3C;
    localparam logic [5:0]  EVSEL_DEF = 6'h3F;
    localparam logic [16:0] RAT_MAX   = 17'h1E848;
    localparam logic [2:0]  ILIM_SCL  = 3'h5;
    localparam logic [1:0]  VPOS_DIV  = 2'h3;
    localparam logic [6:0]  PCT_SCL   = 7'h64;
    // Operating mode codes
    localparam logic [2:0] M_ON     = 3'h0;
    localparam logic [2:0] M_BLK    = 3'h1;
    localparam logic [2:0] M_TEST   = 3'h2;
    localparam logic [2:0] M_TSTBLK = 3'h3;
    localparam logic [2:0] M_OFF    = 3'h4;
    // Condition codes
    localparam logic [1:0] C_NORMAL = 2'h0;
    localparam logic [1:0] C_START  = 2'h1;
    localparam logic [1:0] C_TRIP   = 2'h2;
    localparam logic [1:0] C_BLKD   = 2'h3;
    // Event codes: bit index into the event select field
    localparam logic [2:0] E_STA_ON  = 3'h0;
    localparam logic [2:0] E_STA_OFF = 3'h1;
    localparam logic [2:0] E_TRP_ON  = 3'h2;
    localparam logic [2:0] E_TRP_OFF = 3'h3;
    localparam logic [2:0] E_BLK_ON  = 3'h4;
    localparam logic [2:0] E_BLK_OFF = 3'h5;
    // Measurement set from the front end
    typedef struct packed {
        logic [15:0] ia;
        logic [15:0] ib;
        logic [15:0] ic;
        logic [15:0] v1;
        logic [15:0] v2;
        logic [15:0] v3;
        logic [15:0] v4;
    } aet_meas_t;
    // One record of the log
    typedef struct packed {
        logic [31:0] ts;
        logic [2:0]  code;
        logic [2:0]  sgrp;
        logic [15:0] ia;
        logic [15:0] ib;
        logic [15:0] ic;
        logic [15:0] vab;
        logic [15:0] vbc;
        logic [15:0] vca;
    } aet_log_t;
    // Event message
    typedef struct packed {
        logic        valid;
        logic [2:0]  code;
        logic [31:0] ts;
    } aet_evt_t;
endpackage
`default_nettype wire

// [hdl/aet_top.sv]
// Accidental energize trip: undervoltage arms a start, overcurrent on all
// phases while armed trips. Holds settings, events, counters and a log.
// Assumes measurements, blocking, time and setting group come from logic
// on the same clock; the bus master never issues read and write together.
//
// How it works
// - Magnitudes latched every 5 ms cycle
// - Mode On/Blk/Test/TestBlk/Off, gated write
// - Forced status when forcing is enabled
// - Undervoltage held for activation delay starts
// - Undervoltage limit 0..99 percent, default 50
// - Release delay holds start after recovery
// - Start plus all phases over limit trips
// - Trip also during release countdown
// - Group settings live, mode kept static
// - Blocking sampled at each cycle start
// - Unblocked pick-up gives start
// - Blocked pick-up gives blocked only
// - Block after start runs release timing
// - Stamped on/off events, per-event selection
// - Clearable start/trip/blocked counters
// - Twelve newest on-event records kept
// - Expected and remaining operating time
// - Positive-sequence voltage to setting ratio
// - Lowest phase current to setting ratio
//
// Local design decisions: strobed register access and the register addresses.
`default_nettype none
module aet_top #(
    parameter int unsigned P_TICK_CYCLES = aet_pkg::TICK_CYCLES
) (
    // Clock and reset
    input  wire logic               I_CLK,
    input  wire logic               I_RST,
    // Front end and system
    input  wire aet_pkg::aet_meas_t I_MEAS,
    input  wire logic               I_BLOCK,
    input  wire logic [31:0]        I_TIME,
    input  wire logic [2:0]         I_SGRP,
    // Register port
    input  wire logic [7:0]         I_ADDR,
    input  wire logic [31:0]        I_WDATA,
    input  wire logic               I_WR,
    input  wire logic               I_RD,
    output logic      [31:0]        O_RDATA,
    // Protection outputs
    output logic                    O_START,
    output logic                    O_TRIP,
    output logic                    O_BLOCKED,
    output logic      [1:0]         O_COND,
    output aet_pkg::aet_evt_t       O_EVT
);
    generate
        if (P_TICK_CYCLES < 2)
        begin : g_chk
            $error("P_TICK_CYCLES must be at least 2");
        end
    endgenerate

    typedef enum logic [2:0] {
        ST_IDLE, ST_ARM, ST_START, ST_REL, ST_TRIP, ST_BLK
    } aet_state_t;

    // Quotient num/den saturated at the ratio maximum
    function automatic logic [16:0] ratio(input logic [31:0] num,
                                          input logic [31:0] den);
        logic [31:0] q;
        q = 32'h0;
        if (den == 32'h0)
            return aet_pkg::RAT_MAX;
        q = num / den;
        if (q > 32'(aet_pkg::RAT_MAX))
            return aet_pkg::RAT_MAX;
        return q[16:0];
    endfunction

    // Saturate a written delay at its top value
    function automatic logic [18:0] clamp_dly(input logic [31:0] v);
        if (v > 32'(aet_pkg::DLY_MAX))
            return aet_pkg::DLY_MAX;
        return v[18:0];
    endfunction

    // Settings and state
    logic [1:0]  gen_q;
    logic [2:0]  mode_q;
    logic [1:0]  force_q;
    logic [13:0] uv_q;
    logic [18:0] act_q;
    logic [18:0] rel_q;
    logic [5:0]  ilim_q;
    logic [5:0]  evsel_q;
    logic [6:0]  lsel_q;
    logic [31:0] tcnt_q;
    logic        tick_q;
    logic        eval_q;
    aet_pkg::aet_meas_t meas_q;
    logic        blk_q;
    aet_state_t  st_q;
    aet_state_t  st_d;
    logic [18:0] cnt_q;
    logic [18:0] cnt_d;
    logic [2:0]  flg_q;
    logic [5:0]  pend_q;
    logic [15:0] csta_q;
    logic [15:0] ctrp_q;
    logic [15:0] cblk_q;
    aet_pkg::aet_log_t log_q [aet_pkg::LOG_N];
    logic [3:0]  wptr_q;
    logic [3:0]  lcnt_q;
    logic [19:0] remt_q;
    logic [16:0] vrat_q;
    logic [16:0] irat_q;

    // Derived terms
    logic        wr_cclr;
    logic [15:0] vmax;
    logic [15:0] imin;
    logic [15:0] ithr;
    logic        uv;
    logic        oc;
    logic        blk_eff;
    logic        test_m;
    logic [1:0]  cond_d;
    logic [2:0]  flg_d;
    logic [5:0]  edges;
    logic [5:0]  sent;
    logic [2:0]  ecode;
    logic        evalid;
    logic [3:0]  ridx;
    aet_pkg::aet_log_t rent;
    logic [31:0] ldat;
    logic [31:0] rmux;

    // Program cycle time base; eval follows the sampling edge by one clock
    always_ff @(posedge I_CLK)
    begin
        if (I_RST || tcnt_q == 32'(P_TICK_CYCLES - 1))
            tcnt_q <= 32'h0;
        else
            tcnt_q <= tcnt_q + 32'h1;
        tick_q <= !I_RST && tcnt_q == 32'(P_TICK_CYCLES - 1);
        eval_q <= !I_RST && tick_q;
    end

    // Latch inputs at the start of each program cycle
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            meas_q <= '0;
            blk_q  <= 1'b0;
        end
        else if (tick_q)
        begin
            meas_q <= I_MEAS;
            blk_q  <= I_BLOCK;
        end
    end

    // Settings writes; group settings may change while running
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            gen_q   <= 2'h0;
            mode_q  <= aet_pkg::M_ON;
            force_q <= aet_pkg::C_NORMAL;
            uv_q    <= aet_pkg::UV_DEF;
            act_q   <= aet_pkg::ACT_DEF;
            rel_q   <= aet_pkg::REL_DEF;
            ilim_q  <= aet_pkg::ILIM_DEF;
            evsel_q <= aet_pkg::EVSEL_DEF;
            lsel_q  <= 7'h0;
        end
        else if (I_WR)
        begin
            unique case (I_ADDR)
                aet_pkg::A_GEN:   gen_q <= I_WDATA[1:0];
                aet_pkg::A_MODE:
                    if (gen_q[0] && I_WDATA[2:0] <= aet_pkg::M_OFF)
                        mode_q <= I_WDATA[2:0];
                aet_pkg::A_FORCE: force_q <= I_WDATA[1:0];
                aet_pkg::A_UVLIM:
                    uv_q <= (I_WDATA > 32'(aet_pkg::UV_MAX)) ?
                            aet_pkg::UV_MAX : I_WDATA[13:0];
                aet_pkg::A_ACTD:  act_q <= clamp_dly(I_WDATA);
                aet_pkg::A_RELD:  rel_q <= clamp_dly(I_WDATA);
                aet_pkg::A_ILIM:
                    if (I_WDATA > 32'(aet_pkg::ILIM_MAX))
                        ilim_q <= aet_pkg::ILIM_MAX;
                    else if (I_WDATA == 32'h0)
                        ilim_q <= aet_pkg::ILIM_DEF;
                    else
                        ilim_q <= I_WDATA[5:0];
                aet_pkg::A_EVSEL: evsel_q <= I_WDATA[5:0];
                aet_pkg::A_LSEL:  lsel_q <= I_WDATA[6:0];
                default: ;
            endcase
        end
    end

    assign wr_cclr = I_WR && I_ADDR == aet_pkg::A_CCLR;

    // Pick-up terms from the latched measurement set
    always_comb
    begin
        vmax = meas_q.v1;
        if (meas_q.v2 > vmax)
            vmax = meas_q.v2;
        if (meas_q.v3 > vmax)
            vmax = meas_q.v3;
        imin = meas_q.ia;
        if (meas_q.ib < imin)
            imin = meas_q.ib;
        if (meas_q.ic < imin)
            imin = meas_q.ic;
        ithr    = 16'(ilim_q * aet_pkg::ILIM_SCL);
        uv      = vmax < 16'(uv_q);
        oc      = imin > ithr;
        blk_eff = blk_q || mode_q == aet_pkg::M_BLK
                  || mode_q == aet_pkg::M_TSTBLK;
        test_m  = mode_q == aet_pkg::M_TEST
                  || mode_q == aet_pkg::M_TSTBLK;
    end

    // Protection sequence, stepped once per program cycle
    always_comb
    begin
        st_d  = st_q;
        cnt_d = cnt_q;
        if (eval_q)
        begin
            unique case (st_q)
                ST_IDLE:
                    if (uv)
                    begin
                        cnt_d = 19'h1;
                        if (act_q != 19'h0)
                            st_d = ST_ARM;
                        else
                            st_d = blk_eff ? ST_BLK : ST_START;
                    end
                ST_ARM:
                    if (!uv)
                        st_d = ST_IDLE;
                    else if (cnt_q >= act_q)
                        st_d = blk_eff ? ST_BLK : ST_START;
                    else
                        cnt_d = cnt_q + 19'h1;
                ST_START:
                    if (oc && !blk_eff)
                        st_d = ST_TRIP;
                    else if (!uv || blk_eff)
                    begin
                        cnt_d = 19'h1;
                        st_d  = (rel_q == 19'h0) ?
                                ST_IDLE : ST_REL;
                    end
                ST_REL:
                    if (oc && !blk_eff)
                        st_d = ST_TRIP;
                    else if (uv && !blk_eff)
                        st_d = ST_START;
                    else if (cnt_q >= rel_q)
                        st_d = ST_IDLE;
                    else
                        cnt_d = cnt_q + 19'h1;
                ST_TRIP:
                    if (!oc)
                    begin
                        cnt_d = 19'h1;
                        st_d  = (uv && !blk_eff) ? ST_START : ST_REL;
                    end
                ST_BLK:
                    if (!blk_eff)
                        st_d = ST_IDLE;
            endcase
        end
        if (mode_q == aet_pkg::M_OFF)
            st_d = ST_IDLE;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            st_q  <= ST_IDLE;
            cnt_q <= 19'h0;
        end
        else
        begin
            st_q  <= st_d;
            cnt_q <= cnt_d;
        end
    end

    // Reported condition, optionally forced
    always_comb
    begin
        unique case (st_q)
            ST_START, ST_REL: cond_d = aet_pkg::C_START;
            ST_TRIP:          cond_d = aet_pkg::C_TRIP;
            ST_BLK:           cond_d = aet_pkg::C_BLKD;
            default:          cond_d = aet_pkg::C_NORMAL;
        endcase
        if (gen_q[1] && force_q != aet_pkg::C_NORMAL)
            cond_d = force_q;
        flg_d[0] = cond_d == aet_pkg::C_START
                   || cond_d == aet_pkg::C_TRIP;
        flg_d[1] = cond_d == aet_pkg::C_TRIP;
        flg_d[2] = cond_d == aet_pkg::C_BLKD;
        edges    = {flg_q[2] & ~flg_d[2], ~flg_q[2] & flg_d[2],
                    flg_q[1] & ~flg_d[1], ~flg_q[1] & flg_d[1],
                    flg_q[0] & ~flg_d[0], ~flg_q[0] & flg_d[0]};
    end

    // Outputs; test modes keep the trip contact quiet
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            flg_q     <= 3'h0;
            O_COND    <= aet_pkg::C_NORMAL;
            O_START   <= 1'b0;
            O_TRIP    <= 1'b0;
            O_BLOCKED <= 1'b0;
        end
        else
        begin
            flg_q     <= flg_d;
            O_COND    <= cond_d;
            O_START   <= flg_d[0];
            O_TRIP    <= flg_d[1] && !test_m;
            O_BLOCKED <= flg_d[2];
        end
    end

    // Pick the lowest pending event; one leaves per clock
    always_comb
    begin
        ecode  = 3'h0;
        evalid = 1'b0;
        sent   = 6'h0;
        for (int i = 5; i >= 0; i--)
        begin
            if (pend_q[i])
            begin
                ecode  = 3'(i);
                evalid = 1'b1;
                sent   = 6'h1 << i;
            end
        end
    end

    // Pending events: a new edge wins over the bit being sent
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            pend_q <= 6'h0;
            O_EVT  <= '0;
        end
        else
        begin
            pend_q      <= (pend_q & ~sent) | (edges & evsel_q);
            O_EVT.valid <= evalid;
            O_EVT.code  <= ecode;
            O_EVT.ts    <= I_TIME;
        end
    end

    // Counters: an increment in the clearing cycle still counts
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            csta_q <= 16'h0;
            ctrp_q <= 16'h0;
            cblk_q <= 16'h0;
        end
        else
        begin
            csta_q <= (wr_cclr && I_WDATA[0] ? 16'h0 : csta_q)
                      + 16'(edges[aet_pkg::E_STA_ON]);
            ctrp_q <= (wr_cclr && I_WDATA[1] ? 16'h0 : ctrp_q)
                      + 16'(edges[aet_pkg::E_TRP_ON]);
            cblk_q <= (wr_cclr && I_WDATA[2] ? 16'h0 : cblk_q)
                      + 16'(edges[aet_pkg::E_BLK_ON]);
        end
    end

    // Ring of records; the oldest is overwritten when full
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            wptr_q <= 4'h0;
            lcnt_q <= 4'h0;
        end
        else if (|{edges[aet_pkg::E_STA_ON], edges[aet_pkg::E_TRP_ON],
                   edges[aet_pkg::E_BLK_ON]})
        begin
            log_q[wptr_q] <= '{ts: I_TIME,
                code: edges[aet_pkg::E_TRP_ON] ? aet_pkg::E_TRP_ON :
                      edges[aet_pkg::E_BLK_ON] ? aet_pkg::E_BLK_ON :
                      aet_pkg::E_STA_ON,
                sgrp: I_SGRP, ia: meas_q.ia, ib: meas_q.ib,
                ic: meas_q.ic, vab: meas_q.v1, vbc: meas_q.v2,
                vca: meas_q.v3};
            wptr_q <= (wptr_q == 4'(aet_pkg::LOG_N - 1)) ?
                      4'h0 : wptr_q + 4'h1;
            if (lcnt_q != 4'(aet_pkg::LOG_N))
                lcnt_q <= lcnt_q + 4'h1;
        end
    end

    // Timing and ratio readouts, refreshed every clock
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
        begin
            remt_q <= 20'h0;
            vrat_q <= 17'h0;
            irat_q <= 17'h0;
        end
        else
        begin
            remt_q <= (st_q == ST_ARM) ?
                      {1'b0, act_q} - {1'b0, cnt_q} : 20'h0;
            vrat_q <= ratio((32'(meas_q.v1) + 32'(meas_q.v2)
                            + 32'(meas_q.v3)) * 32'(aet_pkg::PCT_SCL),
                            32'(uv_q) * 32'(aet_pkg::VPOS_DIV));
            irat_q <= ratio(32'(imin) * 32'(aet_pkg::PCT_SCL),
                            32'(ithr));
        end
    end

    // Log readout: selected age counted back from the newest entry
    always_comb
    begin
        ridx = 4'((32'(wptr_q) + 32'(aet_pkg::LOG_N) - 32'h1
                   - 32'(lsel_q[3:0])) % 32'(aet_pkg::LOG_N));
        rent = log_q[ridx];
        ldat = 32'h0;
        if (lsel_q[3:0] < lcnt_q)
        begin
            unique case (lsel_q[6:4])
                3'h0: ldat = rent.ts;
                3'h1: ldat = {26'h0, rent.sgrp, rent.code};
                3'h2: ldat = {16'h0, rent.ia};
                3'h3: ldat = {16'h0, rent.ib};
                3'h4: ldat = {16'h0, rent.ic};
                3'h5: ldat = {16'h0, rent.vab};
                3'h6: ldat = {16'h0, rent.vbc};
                3'h7: ldat = {16'h0, rent.vca};
            endcase
        end
    end

    // Read decode; unmapped addresses read as zero
    always_comb
    begin
        unique case (I_ADDR)
            aet_pkg::A_GEN:   rmux = {30'h0, gen_q};
            aet_pkg::A_MODE:  rmux = {29'h0, mode_q};
            aet_pkg::A_FORCE: rmux = {30'h0, force_q};
            aet_pkg::A_UVLIM: rmux = {18'h0, uv_q};
            aet_pkg::A_ACTD:  rmux = {13'h0, act_q};
            aet_pkg::A_RELD:  rmux = {13'h0, rel_q};
            aet_pkg::A_ILIM:  rmux = {26'h0, ilim_q};
            aet_pkg::A_EVSEL: rmux = {26'h0, evsel_q};
            aet_pkg::A_STAT:  rmux = {24'h0, mode_q, flg_q, O_COND};
            aet_pkg::A_EXPT:  rmux = {13'h0, act_q};
            aet_pkg::A_REMT:  rmux = {{12{remt_q[19]}}, remt_q};
            aet_pkg::A_VRAT:  rmux = {15'h0, vrat_q};
            aet_pkg::A_IRAT:  rmux = {15'h0, irat_q};
            aet_pkg::A_CSTA:  rmux = {16'h0, csta_q};
            aet_pkg::A_CTRP:  rmux = {16'h0, ctrp_q};
            aet_pkg::A_CBLK:  rmux = {16'h0, cblk_q};
            aet_pkg::A_LSEL:  rmux = {25'h0, lsel_q};
            aet_pkg::A_LDAT:  rmux = ldat;
            aet_pkg::A_LCNT:  rmux = {28'h0, lcnt_q};
            default:          rmux = 32'h0;
        endcase
    end

    // Read data stand for exactly the cycle after the strobe
    always_ff @(posedge I_CLK)
    begin
        if (I_RST)
            O_RDATA <= 32'h0;
        else
            O_RDATA <= I_RD ? rmux : 32'h0;
    end
endmodule // aet_top
`default_nettype wire

// [tb/aet_frontend.sv]
// Model of the measurement front end and the blocking matrix.
// Assumes the block keeps its default voltage and current limits.
`default_nettype none
module aet_frontend (
    // Clock
    input  wire logic              i_clk,
    // Wanted conditions
    input  wire logic              i_uv,
    input  wire logic              i_oc,
    input  wire logic              i_blk,
    // Towards the block
    output var aet_pkg::aet_meas_t o_meas,
    output var logic               o_blk
);
    timeunit 1ns;
    timeprecision 1ns;
    // Noise keeps every sample on the wanted side of the limit
    function automatic logic [15:0] mag(input logic hi, input int span,
                                        input int base);
        return 16'((hi ? base : 0) + $urandom % span);
    endfunction
    // Fresh values every clock; the block only looks at its ticks
    always @(posedge i_clk)
    begin
        o_meas.ia <= mag(i_oc, 5, 100);
        o_meas.ib <= mag(i_oc, 5, 100);
        o_meas.ic <= mag(i_oc, 5, 100);
        o_meas.v1 <= mag(!i_uv, 4000, 6000);
        o_meas.v2 <= mag(!i_uv, 4000, 6000);
        o_meas.v3 <= mag(!i_uv, 4000, 6000);
        o_meas.v4 <= mag(1'b0, 9000, 0);
        o_blk     <= i_blk;
    end
endmodule // aet_frontend
`default_nettype wire

// [tb/aet_props.sv]
// Checker on the top-level outputs of the energize trip block.
// Assumes a program cycle of at least eight clocks.
`default_nettype none
module aet_props #(
    parameter int unsigned P_TICK_CYCLES = 8
) (
    input wire logic              I_CLK,
    input wire logic              I_RST,
    input wire logic              O_START,
    input wire logic              O_TRIP,
    input wire logic              O_BLOCKED,
    input wire aet_pkg::aet_evt_t O_EVT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_RST);
    // Valid over code: 8 start on, 9 start off, A trip on, C block on
    wire logic [3:0] ev = {O_EVT.valid, O_EVT.code};
    property p_tr; O_TRIP |-> O_START; endproperty
    a_tr: assert property (p_tr)
        else $error("trip alone");
    property p_bs; O_BLOCKED |-> !O_START; endproperty
    a_bs: assert property (p_bs)
        else $error("start while blocked");
    // Start and blocked outputs move at most once per program cycle
    property p_st; $changed(O_START) |=> $stable(O_START)[*6]; endproperty
    a_st: assert property (p_st)
        else $error("start moved between ticks");
    property p_bk;
        $changed(O_BLOCKED) |=> $stable(O_BLOCKED)[*6];
    endproperty
    a_bk: assert property (p_bk)
        else $error("blocked moved between ticks");
    // Start on/off, trip on and block on edges are announced within a few clocks
    property p_son; $rose(O_START) |-> ##[1:4] (ev == 4'h8); endproperty
    a_son: assert property (p_son)
        else $error("no start on event");
    property p_sof; $fell(O_START) |-> ##[1:4] (ev == 4'h9); endproperty
    a_sof: assert property (p_sof)
        else $error("no start off event");
    property p_ton; $rose(O_TRIP) |-> ##[1:4] (ev == 4'hA); endproperty
    a_ton: assert property (p_ton)
        else $error("no trip on event");
    property p_bon; $rose(O_BLOCKED) |-> ##[1:4] (ev == 4'hC); endproperty
    a_bon: assert property (p_bon)
        else $error("no block on event");
endmodule // aet_props
bind aet_top aet_props #(.P_TICK_CYCLES(P_TICK_CYCLES)) u_props (
    .I_CLK(I_CLK), .I_RST(I_RST), .O_START(O_START), .O_TRIP(O_TRIP),
    .O_BLOCKED(O_BLOCKED), .O_EVT(O_EVT));
`default_nettype wire

// [tb/aet_top_test.sv]
// Self-checking bench for the energize trip block and its front end.
// Assumes an eight-clock program cycle; expectations queue in order.
`default_nettype none
module aet_top_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic               clk, rst, wr, rd, rd_q, uv, oc, bw, blk;
    logic               start, trip, blkd;
    logic [7:0]         addr;
    logic [31:0]        wdat, rdat, rq[$];
    logic [1:0]         cond;
    logic [2:0]         eq[$];
    int                 n_mismatch, compares, n, cnt[6];
    aet_pkg::aet_meas_t meas;
    aet_pkg::aet_evt_t  evt;
    aet_frontend u_fe (.i_clk(clk), .i_uv(uv), .i_oc(oc), .i_blk(bw),
        .o_meas(meas), .o_blk(blk));
    aet_top #(.P_TICK_CYCLES(8)) u_dut (.I_CLK(clk), .I_RST(rst),
        .I_MEAS(meas), .I_BLOCK(blk), .I_TIME(32'h0), .I_SGRP(3'h2),
        .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr), .I_RD(rd),
        .O_RDATA(rdat), .O_START(start), .O_TRIP(trip),
        .O_BLOCKED(blkd), .O_COND(cond), .O_EVT(evt));
    task automatic chk(input logic [31:0] s, e, input string what);
        compares++;
        if (s !== e)
        begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic tally_and_finish;
        if (n_mismatch == 0 && compares > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // A free cycle after each strobe, so no strobe is set twice at once
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        if (!w)
            rq.push_back(d);
        addr <= a;
        wdat <= d;
        wr <= w;
        rd <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic ev(input logic [2:0] c);
        eq.push_back(c);
        cnt[c]++;
    endtask
    // Levels are looked at mid-cycle, away from the updating edge
    task automatic wait_for(ref logic s, input logic v);
        n = 0;
        while (s !== v && n < 400)
        begin
            @(negedge clk);
            n++;
        end
        @(posedge clk) n_mismatch += (n >= 400);
    endtask
    task automatic arm;
        uv <= 1'b1;
        ev(aet_pkg::E_STA_ON);
        wait_for(start, 1'b1);
        chk(32'(cond), 32'(aet_pkg::C_START), "condition");
    endtask
    task automatic pulse_oc;
        oc <= 1'b1;
        ev(aet_pkg::E_TRP_ON);
        wait_for(trip, 1'b1);
        oc <= 1'b0;
        ev(aet_pkg::E_TRP_OFF);
        wait_for(trip, 1'b0);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Oldest note is matched against each answer as it appears
    always @(posedge clk)
    begin
        rd_q <= rd;
        if (rd_q)
            chk(rdat, rq.pop_front(), "read data");
        if (evt.valid === 1'b1)
            chk(32'(evt.code), 32'(eq.size() ? eq.pop_front() : 3'h7),
                "event code");
    end
    // The run needs well under a thousand clocks
    initial
    begin
        #(20 * 6000);
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        {wr, rd, uv, oc, bw, addr, wdat} = '0;
        rst = 1'b1;
        void'($urandom(32'h679D));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Defaults, saturation, an unmapped place and the mode gate
        bus(1'b0, aet_pkg::A_ACTD, 32'(aet_pkg::ACT_DEF));
        bus(1'b0, aet_pkg::A_RELD, 32'(aet_pkg::REL_DEF));
        bus(1'b0, aet_pkg::A_EVSEL, 32'(aet_pkg::EVSEL_DEF));
        bus(1'b0, 8'hFC, 32'h0);
        bus(1'b1, aet_pkg::A_UVLIM, 32'hFFFF);
        bus(1'b0, aet_pkg::A_UVLIM, 32'(aet_pkg::UV_MAX));
        bus(1'b1, aet_pkg::A_UVLIM, 32'(aet_pkg::UV_DEF));
        bus(1'b1, aet_pkg::A_MODE, 32'h2);
        bus(1'b0, aet_pkg::A_MODE, 32'h0);
        bus(1'b1, aet_pkg::A_GEN, 32'h1);
        bus(1'b1, aet_pkg::A_MODE, 32'h2);
        bus(1'b0, aet_pkg::A_MODE, 32'h2);
        bus(1'b1, aet_pkg::A_MODE, 32'h0);
        bus(1'b1, aet_pkg::A_ACTD, 32'h3);
        bus(1'b1, aet_pkg::A_RELD, 32'h4);
        // Three ticks of undervoltage arm, then overcurrent trips
        arm();
        chk(32'(n inside {[28:37]}), 32'h1, "arm delay");
        pulse_oc();
        // Voltage back: overcurrent during the release countdown trips
        uv <= 1'b0;
        repeat (8) @(posedge clk);
        pulse_oc();
        ev(aet_pkg::E_STA_OFF);
        wait_for(start, 1'b0);
        // Block after start runs the release timing, then blocks pick-up
        arm();
        bw <= 1'b1;
        ev(aet_pkg::E_STA_OFF);
        wait_for(start, 1'b0);
        chk(32'(n inside {[36:45]}), 32'h1, "release delay");
        ev(aet_pkg::E_BLK_ON);
        wait_for(blkd, 1'b1);
        bw <= 1'b0;
        uv <= 1'b0;
        ev(aet_pkg::E_BLK_OFF);
        wait_for(blkd, 1'b0);
        // Counters follow the on events and clear together
        bus(1'b0, aet_pkg::A_CSTA, 32'(cnt[0]));
        bus(1'b0, aet_pkg::A_CTRP, 32'(cnt[2]));
        bus(1'b0, aet_pkg::A_CBLK, 32'(cnt[4]));
        bus(1'b1, aet_pkg::A_CCLR, 32'h7);
        bus(1'b0, aet_pkg::A_CSTA, 32'h0);
        chk(32'(eq.size()), 32'h0, "events left");
        tally_and_finish();
    end
endmodule // aet_top_test
`default_nettype wire
